// [verilog/ppcl_pkg.sv]
// Package: constants and types for the port pin configuration latches
package ppcl_pkg;
  localparam int unsigned PPCL_PINS = 8;

  // Register byte offsets on APB
  localparam logic [7:0] PPCL_OFS_DATA   = 8'h00;
  localparam logic [7:0] PPCL_OFS_CFG_A  = 8'h04;
  localparam logic [7:0] PPCL_OFS_CFG_B  = 8'h08;
  localparam logic [7:0] PPCL_OFS_CFG_C  = 8'h0c;
  localparam logic [7:0] PPCL_OFS_CTRL   = 8'h10;
  localparam logic [7:0] PPCL_OFS_STATUS = 8'h14;

  // Reset values: bidirectional weak pull-up, data all ones
  localparam logic [7:0] PPCL_RST_DATA  = 8'hff;
  localparam logic [7:0] PPCL_RST_CFG   = 8'h00;
  localparam logic [7:0] PPCL_RST_CTRL  = 8'h00;
  localparam logic [7:0] PPCL_RST_INPUT = 8'h00;

  // Control register field positions
  localparam int unsigned PPCL_CTRL_WAIT = 0;
  localparam int unsigned PPCL_CTRL_HALT = 1;

  // Decoded pin configuration codes {c2,c1,c0}
  typedef enum logic [2:0] {
    PPCL_BID_WPU = 3'h0,
    PPCL_OUT_PP  = 3'h2,
    PPCL_IN_CMOS = 3'h1,
    PPCL_ALT_PP  = 3'h3,
    PPCL_BID_OD  = 3'h4,
    PPCL_OUT_OD  = 3'h6,
    PPCL_IN_TTL  = 3'h5,
    PPCL_ALT_OD  = 3'h7
  } ppcl_cfg_type;

  // APB slave phases
  typedef enum logic [1:0] {
    PPCL_IDLE   = 2'b01,
    PPCL_ACCESS = 2'b10
  } ppcl_apb_type;
endpackage

// [verilog/ppcl_pin_decode.sv]
// Per-pin configuration decoder: mode code to driver and latch controls
`timescale 1ns/1ns
module ppcl_pin_decode (
  input  wire logic [2:0] cfg,
  input  wire logic       wpu_allowed,
  output logic            is_input,
  output logic            is_output,
  output logic            is_bid,
  output logic            is_alt,
  output logic            sink_only_drive,
  output logic            weak_pullup,
  output logic            ttl_level
);
  import ppcl_pkg::*;

  // R1 mode decode
  always_comb begin
    is_input        = 1'b0;
    is_output       = 1'b0;
    is_bid          = 1'b0;
    is_alt          = 1'b0;
    sink_only_drive = 1'b0;
    weak_pullup     = 1'b0;
    ttl_level       = 1'b1;
    unique case (ppcl_cfg_type'(cfg))
      PPCL_BID_WPU: begin
        is_bid          = 1'b1;
        sink_only_drive = 1'b1;
        weak_pullup     = wpu_allowed; // Pull-up may be removed in hardware
      end
      PPCL_BID_OD: begin
        is_bid          = 1'b1;
        sink_only_drive = 1'b1;
      end
      PPCL_OUT_PP: is_output = 1'b1;
      PPCL_OUT_OD: begin
        is_output       = 1'b1;
        sink_only_drive = 1'b1;
      end
      PPCL_IN_CMOS: begin
        is_input  = 1'b1;
        ttl_level = 1'b0;
      end
      PPCL_IN_TTL: is_input = 1'b1;
      PPCL_ALT_PP: is_alt = 1'b1;
      PPCL_ALT_OD: begin
        is_alt          = 1'b1;
        sink_only_drive = 1'b1;
      end
    endcase
  end
endmodule // ppcl_pin_decode

// [verilog/ppcl_apb_slave.sv]
// APB slave front end: decodes phases, yields one-cycle read/write strobes
`timescale 1ns/1ns
module ppcl_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  output logic             pready,
  output logic             pslverr,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       reg_addr,
  input  wire logic        addr_ok
);
  import ppcl_pkg::*;

  ppcl_apb_type state_ff;
  logic         in_access;

  // Phase tracker; access always completes in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PPCL_IDLE;
    end else begin
      unique case (state_ff)
        PPCL_IDLE:   state_ff <= (psel && !penable) ? PPCL_ACCESS : PPCL_IDLE;
        PPCL_ACCESS: state_ff <= PPCL_IDLE;
      endcase
    end
  end

  // Strobes only in a tracked access phase; a penable without a setup cycle does nothing
  assign in_access = (state_ff == PPCL_ACCESS);

  // Zero wait states keep the core strobes simple
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && in_access && !addr_ok;
  assign wr_stb   = psel && penable && in_access && pwrite && addr_ok;
  assign rd_stb   = psel && penable && in_access && !pwrite;
  assign reg_addr = paddr;
endmodule // ppcl_apb_slave

// [verilog/ppcl_port.sv]
// Eight-pin port: configuration, master/slave/input latches, APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
// Function
// R1 - Three config bits select pin mode
// R2 - Input mode keeps driver disabled
// R3 - Input mode samples pin at start
// R4 - Input mode copies master to slave
// R5 - Output drives; master copies to input
// R6 - Bidirectional: open-drain/pull-up, sample, copy
// R7 - Bidirectional read returns pin level
// R8 - Software edits shadow, loads port once
// R9 - Alternate output loads slave from peripheral; here the peripheral drives the pin and the slave keeps the master copy
// R10 - Idle alternate: high or high-impedance
// R11 - Shared peripheral outputs are ANDed
// R12 - Pin feeds alternate inputs always
// R13 - Converter pin forces alternate output high; done here only in alternate open-drain mode
// R14 - Alternate output appears on alternate input
// R15 - Wait and halt keep port state
// R16 - Port write loads output master latch
// R17 - Port read returns input latch
// R18 - Reset: weak pull-up, data all ones
// R19 - Core gives one-cycle begin/end strobes
module ppcl_port #(
  parameter int unsigned    PINS     = ppcl_pkg::PPCL_PINS,
  parameter int unsigned    AF_SRCS  = 2,
  parameter logic [7:0]     WPU_PINS = 8'hff,
  parameter logic [7:0]     ADC_PINS = 8'h00
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 instr_begin,
  input  wire logic                 instr_end,
  input  wire logic [PINS-1:0]      pin_in,
  output logic [PINS-1:0]           pin_out,
  output logic [PINS-1:0]           pin_oe,
  output logic [PINS-1:0]           pin_pullup,
  output logic [PINS-1:0]           pin_ttl,
  input  wire logic [AF_SRCS*PINS-1:0] periph_drive_mode,
  input  wire logic [PINS-1:0]      af_connected,
  output logic [PINS-1:0]           periph_sense_mode,
  output logic                      clk_out_run
);
  import ppcl_pkg::*;

  logic [7:0]      master_ff;
  logic [7:0]      slave_ff;
  logic [7:0]      input_ff;
  logic [7:0]      cfg_a_ff;
  logic [7:0]      cfg_b_ff;
  logic [7:0]      cfg_c_ff;
  logic [1:0]      ctrl_ff;
  logic [31:0]     prdata_ff;
  logic [31:0]     nxt_prdata;
  logic            wr_stb;
  logic            rd_stb;
  logic [7:0]      reg_addr;
  logic            addr_ok;
  logic            frozen;
  logic [PINS-1:0] is_input;
  logic [PINS-1:0] is_output;
  logic [PINS-1:0] is_bid;
  logic [PINS-1:0] is_alt;
  logic [PINS-1:0] sink_only;
  logic [PINS-1:0] weak_pu;
  logic [PINS-1:0] ttl_lvl;
  logic [PINS-1:0] af_and;
  logic [PINS-1:0] drive_val;
  logic [PINS-1:0] pin_level;

  ppcl_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .reg_addr (reg_addr),
    .addr_ok  (addr_ok)
  );

  // Address decode for the six word registers
  always_comb begin
    addr_ok = (reg_addr == PPCL_OFS_DATA)  || (reg_addr == PPCL_OFS_CFG_A) ||
              (reg_addr == PPCL_OFS_CFG_B) || (reg_addr == PPCL_OFS_CFG_C) ||
              (reg_addr == PPCL_OFS_CTRL)  || (reg_addr == PPCL_OFS_STATUS);
  end

  // R15 state frozen in wait or halt
  assign frozen      = ctrl_ff[PPCL_CTRL_WAIT] || ctrl_ff[PPCL_CTRL_HALT];
  // R15 clocks stop only in halt
  assign clk_out_run = !ctrl_ff[PPCL_CTRL_HALT];

  // Per-pin decode and alternate output combining
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic [AF_SRCS-1:0] srcs;

    ppcl_pin_decode u_dec (
      .cfg             ({cfg_c_ff[i], cfg_b_ff[i], cfg_a_ff[i]}),
      .wpu_allowed     (WPU_PINS[i]),
      .is_input        (is_input[i]),
      .is_output       (is_output[i]),
      .is_bid          (is_bid[i]),
      .is_alt          (is_alt[i]),
      .sink_only_drive (sink_only[i]),
      .weak_pullup     (weak_pu[i]),
      .ttl_level       (ttl_lvl[i])
    );

    for (genvar s = 0; s < AF_SRCS; s++) begin : g_src
      assign srcs[s] = periph_drive_mode[s*PINS+i];
    end

    always_comb begin
      // R11 AND shared outputs; R10 idle drives high
      af_and[i] = (&srcs) | !af_connected[i];
      // R13 converter pin held high in alternate open-drain mode only
      if (ADC_PINS[i] && (ppcl_cfg_type'({cfg_c_ff[i], cfg_b_ff[i], cfg_a_ff[i]}) == PPCL_ALT_OD)) begin
        af_and[i] = 1'b1;
      end
    end

    // R9 peripheral value reaches the pin directly
    assign drive_val[i] = is_alt[i] ? af_and[i] : slave_ff[i];

    always_comb begin
      // R2 input never drives
      pin_oe[i] = 1'b0;
      if (!is_input[i]) begin
        // R5 R6 sink-only drives low only; R10 idle open-drain floats
        pin_oe[i] = sink_only[i] ? !drive_val[i] : 1'b1;
      end
    end

    // R14 driven value seen on alternate input
    assign pin_level[i] = pin_oe[i] ? drive_val[i] : pin_in[i];
  end

  assign pin_out    = drive_val;
  assign pin_pullup = weak_pu;
  assign pin_ttl    = ttl_lvl;
  // R12 pin feeds alternate inputs in every mode
  assign periph_sense_mode      = pin_level;

  // R16 port write fills master latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_ff <= PPCL_RST_DATA;
    end else if (wr_stb && reg_addr == PPCL_OFS_DATA) begin
      master_ff <= pwdata[7:0];
    end
  end

  // Configuration and mode control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R18 reset to bidirectional weak pull-up
      cfg_a_ff <= PPCL_RST_CFG;
      cfg_b_ff <= PPCL_RST_CFG;
      cfg_c_ff <= PPCL_RST_CFG;
      ctrl_ff  <= PPCL_RST_CTRL[1:0];
    end else if (wr_stb) begin
      if (reg_addr == PPCL_OFS_CFG_A) begin
        cfg_a_ff <= pwdata[7:0];
      end
      if (reg_addr == PPCL_OFS_CFG_B) begin
        cfg_b_ff <= pwdata[7:0];
      end
      if (reg_addr == PPCL_OFS_CFG_C) begin
        cfg_c_ff <= pwdata[7:0];
      end
      if (reg_addr == PPCL_OFS_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
    end
  end

  // Slave latch: updated at instruction end, held while frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_ff <= PPCL_RST_DATA;
    end else if (instr_end && !frozen) begin
      // R4 R5 R6 master copied at end
      slave_ff <= master_ff;
    end
  end

  // Input latch: pin sampled at begin, or master at end for outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_ff <= PPCL_RST_INPUT;
    end else if (!frozen) begin
      for (int i = 0; i < PINS; i++) begin
        if (is_output[i]) begin
          // R5 output copies master at end
          if (instr_end) begin
            input_ff[i] <= master_ff[i];
          end
        end else if (instr_begin) begin
          // R3 R6 R7 R9 pin sampled at start
          input_ff[i] <= pin_level[i];
        end
      end
    end
  end

  // Read mux; R17 data reads return input latch
  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_stb) begin
      nxt_prdata = 32'h0000_0000;
      unique case (reg_addr)
        PPCL_OFS_DATA:   nxt_prdata[7:0] = input_ff;
        PPCL_OFS_CFG_A:  nxt_prdata[7:0] = cfg_a_ff;
        PPCL_OFS_CFG_B:  nxt_prdata[7:0] = cfg_b_ff;
        PPCL_OFS_CFG_C:  nxt_prdata[7:0] = cfg_c_ff;
        PPCL_OFS_CTRL:   nxt_prdata[1:0] = ctrl_ff;
        PPCL_OFS_STATUS: nxt_prdata[7:0] = slave_ff;
        default:         nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data held in a flop; registered version matches APB timing below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Zero-wait read: value presented combinationally from the flop source
  assign prdata = rd_stb ? nxt_prdata : prdata_ff;

  // Assertions: pin 0 stands for every pin, since each pin is one generate copy
  // R16 write reaches master
  AST_WR_MASTER: assert property (@(posedge pclk) disable iff (!presetn) // R16
    wr_stb && reg_addr == PPCL_OFS_DATA |=> master_ff == $past(pwdata[7:0]))
    else $error("master latch missed write");

  // R4 end copies master
  AST_END_SLAVE: assert property (@(posedge pclk) disable iff (!presetn) // R4
    instr_end && !frozen |=> slave_ff == $past(master_ff))
    else $error("slave latch missed copy");

  // R15 frozen holds slave
  AST_FROZEN: assert property (@(posedge pclk) disable iff (!presetn) // R15
    frozen |=> $stable(slave_ff))
    else $error("slave changed while frozen");

  // R2 input never drives
  AST_IN_HIZ: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (is_input & pin_oe) == '0)
    else $error("input pin driven");

  // R3 begin samples pin
  AST_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // R3
    instr_begin && !frozen && is_input[0] && !is_output[0] |=> input_ff[0] == $past(pin_level[0]))
    else $error("input latch missed sample");

  // R5 output copies master
  AST_OUT_IN: assert property (@(posedge pclk) disable iff (!presetn) // R5
    instr_end && !frozen && is_output[0] |=> input_ff[0] == $past(master_ff[0]))
    else $error("input latch missed master copy");

  // R17 data read returns input latch
  AST_READ: assert property (@(posedge pclk) disable iff (!presetn) // R17
    rd_stb && reg_addr == PPCL_OFS_DATA |-> prdata[7:0] == input_ff)
    else $error("data read wrong");

  // R15 halt stops clock outputs
  AST_HALT_CLK: assert property (@(posedge pclk) disable iff (!presetn) // R15
    ctrl_ff[PPCL_CTRL_HALT] |-> !clk_out_run)
    else $error("clock output running in halt");

  // R10 idle alternate open-drain floats
  AST_ALT_OD: assert property (@(posedge pclk) disable iff (!presetn) // R10
    is_alt[0] && sink_only[0] && !af_connected[0] |-> !pin_oe[0])
    else $error("idle open-drain alternate driven");

  // R6 R7 bidirectional samples pin
  AST_BID_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // R7
    instr_begin && !frozen && is_bid[0] |=> input_ff[0] == $past(pin_level[0]))
    else $error("bidirectional pin not sampled");

  // R9 alternate output still sampled
  AST_ALT_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // R9
    instr_begin && !frozen && is_alt[0] |=> input_ff[0] == $past(pin_level[0]))
    else $error("alternate pin not sampled");

  // R5 output ignores begin strobe
  AST_OUT_NOSAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // R5
    instr_begin && !instr_end && is_output[0] |=> $stable(input_ff[0]))
    else $error("output pin sampled at begin");

  // R15 frozen holds input latch
  AST_FROZEN_IN: assert property (@(posedge pclk) disable iff (!presetn) // R15
    frozen |=> $stable(input_ff))
    else $error("input latch changed while frozen");

  // R14 driven value loops back
  AST_AF_LOOP: assert property (@(posedge pclk) disable iff (!presetn) // R14
    pin_oe[0] |-> periph_sense_mode[0] == pin_out[0])
    else $error("alternate input misses driven value");

  // R10 idle push-pull drives high
  AST_IDLE_PP: assert property (@(posedge pclk) disable iff (!presetn) // R10
    is_alt[0] && !sink_only[0] && !af_connected[0] |-> pin_oe[0] && pin_out[0])
    else $error("idle push-pull alternate not high");

  // R5 push-pull drives slave
  AST_PP_DRIVE: assert property (@(posedge pclk) disable iff (!presetn) // R5
    is_output[0] && !sink_only[0] |-> pin_oe[0] && pin_out[0] == slave_ff[0])
    else $error("push-pull output not driving slave");

  // R5 R6 open-drain never high
  AST_OD_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R6
    sink_only[0] && pin_oe[0] |-> !pin_out[0])
    else $error("open-drain pin driven high");

  // R6 pull-up only bidirectional
  AST_PULLUP_BID: assert property (@(posedge pclk) disable iff (!presetn) // R6
    pin_pullup[0] |-> is_bid[0])
    else $error("pull-up outside bidirectional mode");

  // Main scenarios the bench should reach
  COV_WRITE:  cover property (@(posedge pclk) wr_stb && reg_addr == PPCL_OFS_DATA);
  COV_COPY:   cover property (@(posedge pclk) instr_end ##[1:16] instr_begin);
  COV_ALT:    cover property (@(posedge pclk) is_alt[0] && pin_oe[0]);
  COV_FREEZE: cover property (@(posedge pclk) frozen && instr_end);
  COV_BID:    cover property (@(posedge pclk) instr_begin && is_bid[0] && !pin_oe[0]);
endmodule // ppcl_port

// [verif/ppcl_pin_model.sv]
// Partner model: pad levels from port drive, outside sources and pull-ups
`timescale 1ns/1ns
module ppcl_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_lvl
);
  logic [7:0] float_ff;

  // Floating pad wanders every cycle so a stale level is never trusted
  always_ff @(posedge pclk) begin
    float_ff <= ~pin_lvl;
  end

  // Port drive wins, then outside source, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] ? 1'b1 : float_ff[i];
    end
  end
endmodule // ppcl_pin_model

// [verif/ppcl_port_tb_top.sv]
// Self-checking bench for the eight-pin port latches
`timescale 1ns/1ns
module ppcl_port_tb_top;
  import ppcl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, instr_begin, instr_end;
  logic        pready, pslverr, clk_out_run, err;
  logic [7:0]  paddr, pin_out, pin_oe, pin_pullup, pin_ttl, periph_sense_mode, af_conn, pin_lvl, ext_val, rd;
  logic [31:0] pwdata, prdata;
  logic [15:0] periph_drive_mode;
  int          mismatches, checks_done;

  ppcl_port i_ppcl_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_begin(instr_begin), .instr_end(instr_end), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_ttl(pin_ttl), .periph_drive_mode(periph_drive_mode), .af_connected(af_conn), .periph_sense_mode(periph_sense_mode),
    .clk_out_run(clk_out_run));

  ppcl_pin_model i_ppcl_pin_model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(8'hff), .ext_val(ext_val), .pin_lvl(pin_lvl));

  always #4 pclk = ~pclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        mismatches++;
        close_out();
      end
      @(posedge pclk);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic strobe(input logic beg);
    @(posedge pclk);
    if (beg) begin
      instr_begin <= 1'b1;
    end else begin
      instr_end <= 1'b1;
    end
    @(posedge pclk);
    instr_begin <= 1'b0;
    instr_end <= 1'b0;
    #1;
  endtask

  // Expected {drive enable, driven level} for a mode, slave bit, peripheral level
  function automatic logic [1:0] drv(input logic [2:0] c, input logic v, input logic a);
    case (c)
      3'h2: drv = {1'b1, v};
      3'h3: drv = {1'b1, a};
      3'h7: drv = {~a, 1'b0};
      3'h1, 3'h5: drv = 2'b00;
      default: drv = {~v, 1'b0};
    endcase
  endfunction

  // First round walks all eight codes, later rounds are random
  task automatic rand_round(input int it);
    logic [2:0] c [8];
    logic [7:0] m, ca, cb, cc, eoe, eout, epu, ettl, elvl, ein;
    logic [1:0] d;
    logic       a;
    m = 8'($urandom);
    @(posedge pclk);
    periph_drive_mode <= 16'($urandom);
    af_conn <= 8'($urandom);
    ext_val <= 8'($urandom);
    for (int i = 0; i < 8; i++) begin
      c[i] = (it == 0) ? 3'(i) : 3'($urandom);
      {cc[i], cb[i], ca[i]} = c[i];
    end
    apb(1'b1, PPCL_OFS_CFG_A, ca);
    apb(1'b1, PPCL_OFS_CFG_B, cb);
    apb(1'b1, PPCL_OFS_CFG_C, cc);
    apb(1'b1, PPCL_OFS_DATA, m);
    strobe(1'b0);
    for (int i = 0; i < 8; i++) begin
      a = af_conn[i] ? (periph_drive_mode[i] & periph_drive_mode[8+i]) : 1'b1;
      d = drv(c[i], m[i], a);
      {eoe[i], eout[i]} = d;
      epu[i] = (c[i] == 3'h0);
      ettl[i] = (c[i] != 3'h1);
      elvl[i] = d[1] ? d[0] : ext_val[i];
      ein[i] = (c[i] == 3'h2 || c[i] == 3'h6) ? m[i] : elvl[i];
    end
    chk(pin_oe, eoe);
    chk(pin_out & pin_oe, eout);
    chk(pin_pullup, epu);
    chk(pin_ttl, ettl);
    chk(periph_sense_mode, elvl);
    apb(1'b0, PPCL_OFS_STATUS, 8'h00);
    chk(rd, m);
    strobe(1'b1);
    apb(1'b0, PPCL_OFS_DATA, 8'h00);
    chk(rd, ein);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, instr_begin, instr_end} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    periph_drive_mode = 16'h0000;
    af_conn = 8'h00;
    ext_val = 8'h00;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(56));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(pin_oe, 8'h00);
    chk(pin_pullup, 8'hff);
    apb(1'b0, PPCL_OFS_STATUS, 8'h00);
    chk(rd, PPCL_RST_DATA);
    for (int it = 0; it < 40; it++) begin
      rand_round(it);
    end
    // Stored value shows at once after leaving input mode
    apb(1'b1, PPCL_OFS_CFG_A, 8'hff);
    apb(1'b1, PPCL_OFS_CFG_B, 8'h00);
    apb(1'b1, PPCL_OFS_CFG_C, 8'h00);
    apb(1'b1, PPCL_OFS_DATA, 8'h5a);
    strobe(1'b0);
    apb(1'b1, PPCL_OFS_CFG_A, 8'h00);
    apb(1'b1, PPCL_OFS_CFG_B, 8'hff);
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'h5a);
    // Wait and halt freeze the pins; halt stops clock outputs
    apb(1'b1, PPCL_OFS_CTRL, 8'h01);
    apb(1'b1, PPCL_OFS_DATA, 8'ha5);
    strobe(1'b0);
    chk(pin_out, 8'h5a);
    chk({7'h0, clk_out_run}, 8'h01);
    apb(1'b1, PPCL_OFS_CTRL, 8'h02);
    strobe(1'b0);
    chk(pin_out, 8'h5a);
    chk({7'h0, clk_out_run}, 8'h00);
    apb(1'b1, PPCL_OFS_CTRL, 8'h00);
    strobe(1'b0);
    chk(pin_out, 8'ha5);
    // Unmapped place: write refused, read gives zero; both flag an error
    apb(1'b1, 8'h18, 8'hff);
    chk({7'h0, err}, 8'h01);
    apb(1'b0, 8'h18, 8'h00);
    chk(rd, 8'h00);
    chk({7'h0, err}, 8'h01);
    // Refused write left the master latch alone
    strobe(1'b0);
    apb(1'b0, PPCL_OFS_STATUS, 8'h00);
    chk(rd, 8'ha5);
    close_out();
  end
endmodule // ppcl_port_tb_top
